// ==== src/wxio_pkg.sv ====
// Constants shared by the welder external discrete control block.
// Assumes a single 50 MHz system clock; contact inputs arrive as levels.
// Contract
// - Beam select 3 input asserted selects beam input unit 3 as ready.
// - Beam select 4 input asserted selects beam input unit 4 as ready.
// - Schedule number is plain binary sum of weights 1, 2, 4, 8, 16.
// - Closed contact is one; all open is schedule 00; codes run to 30.
// - Ready only while high voltage on and capacitor fully charged.
// - High-voltage-on output follows whether high voltage is supplied.
// - Trouble output closed normally; opens on fault, stays open until reset.
// - After each lamp flash, end output pulses for 40 ms.
// - Energy within limits asserts monitor-normal for 40 ms.
// - Energy outside limits asserts monitor-trouble for 40 ms instead.
// - External-input-receivable output follows the changeover input.
// - While not receivable, all external control inputs are ignored.
// - Lamp-power-limit output closed normally, opens when power exceeds reference.
// - Trouble-reset closing, with cause gone, clears the latched alarm.
// - External inputs take effect only while changeover is held closed.
package wxio_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned WXIO_CLK_HZ = 50000000;
	localparam int unsigned WXIO_PULSE_MS = 40;
	localparam int unsigned WXIO_PULSE_CYCLES = (WXIO_CLK_HZ / 1000) * WXIO_PULSE_MS;
	localparam int WXIO_CNT_W = 21;
	// ----------------------------------------------------------------
	// Schedule field
	// ----------------------------------------------------------------
	localparam int WXIO_SCHED_W = 5;
	localparam logic [4:0] WXIO_SCHED_RESET = 5'h00;
	localparam logic [4:0] WXIO_SCHED_MAX = 5'h1e;
	// ----------------------------------------------------------------
	// Synchronised input vector layout
	// ----------------------------------------------------------------
	localparam int WXIO_IN_W = 17;
	localparam int WXIO_IN_CHG = 0;
	localparam int WXIO_IN_BSEL3 = 1;
	localparam int WXIO_IN_BSEL4 = 2;
	localparam int WXIO_IN_SCHED = 3;
	localparam int WXIO_IN_HVREQ = 8;
	localparam int WXIO_IN_TRST = 9;
	localparam int WXIO_IN_HVON = 10;
	localparam int WXIO_IN_CHARGED = 11;
	localparam int WXIO_IN_FAULT = 12;
	localparam int WXIO_IN_FLASH = 13;
	localparam int WXIO_IN_EVAL = 14;
	localparam int WXIO_IN_INRANGE = 15;
	localparam int WXIO_IN_LAMPOVER = 16;
	typedef enum logic [1:0] {
		WXIO_PULSE_IDLE = 2'b00,
		WXIO_PULSE_HIGH = 2'b01
	} wxio_pulse_state_type;
endpackage

// ==== src/wxio_sync.sv ====
// Two-flop synchroniser for a vector of contact levels.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps
`default_nettype none
module wxio_sync
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// Levels
	input wire logic [wxio_pkg::WXIO_IN_W-1:0] async_in,
	output logic [wxio_pkg::WXIO_IN_W-1:0] sync_out
);
	logic [wxio_pkg::WXIO_IN_W-1:0] stage1;
	logic [wxio_pkg::WXIO_IN_W-1:0] stage2;
	logic [wxio_pkg::WXIO_IN_W-1:0] next_stage1;
	logic [wxio_pkg::WXIO_IN_W-1:0] next_stage2;

	always_comb
	begin
		next_stage1 = async_in;
		next_stage2 = stage1;
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			stage1 <= '0;
			stage2 <= '0;
		end
		else
		begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
		end
	end

	assign sync_out = stage2;
endmodule
`default_nettype wire

// ==== src/wxio_pulse.sv ====
// One-shot that holds its output for the 40 ms pulse length unless stop_in ends it early.
// Assumes a one-cycle trigger; a retrigger while busy restarts the count.
`timescale 1ns/1ps
`default_nettype none
module wxio_pulse
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// Trigger and pulse
	input wire logic trig_in,
	input wire logic stop_in,
	output logic pulse_out
);
	localparam logic [wxio_pkg::WXIO_CNT_W-1:0] LAST =
		wxio_pkg::WXIO_CNT_W'(wxio_pkg::WXIO_PULSE_CYCLES - 1);
	wxio_pkg::wxio_pulse_state_type state;
	wxio_pkg::wxio_pulse_state_type next_state;
	logic [wxio_pkg::WXIO_CNT_W-1:0] count;
	logic [wxio_pkg::WXIO_CNT_W-1:0] next_count;

	always_comb
	begin
		next_state = state;
		next_count = count;
		unique case (state)
			wxio_pkg::WXIO_PULSE_IDLE:
			begin
				if (trig_in)
				begin
					next_state = wxio_pkg::WXIO_PULSE_HIGH;
					next_count = '0;
				end
			end
			wxio_pkg::WXIO_PULSE_HIGH:
			begin
				if (trig_in)
				begin
					next_count = '0;
				end
				else if (stop_in || count == LAST)
				begin
					next_state = wxio_pkg::WXIO_PULSE_IDLE;
					next_count = '0;
				end
				else
				begin
					next_count = count + 1'b1;
				end
			end
			default:
			begin
				next_state = wxio_pkg::WXIO_PULSE_IDLE;
				next_count = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state <= wxio_pkg::WXIO_PULSE_IDLE;
			count <= '0;
			pulse_out <= 1'b0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			pulse_out <= (next_state == wxio_pkg::WXIO_PULSE_HIGH);
		end
	end
endmodule
`default_nettype wire

// ==== src/wxio_top.sv ====
// Welder external discrete control: contact inputs in, relay status out.
// Assumes internal status levels come from the welder core; closed contact is one.
`timescale 1ns/1ps
`default_nettype none
module wxio_top
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// Contact inputs from the machine controller
	input wire logic external_control_enable_in,
	input wire logic beam_select3_in,
	input wire logic beam_select4_in,
	input wire logic [4:0] schedule_in,
	input wire logic hv_on_request_in,
	input wire logic trouble_reset_in,
	// Welder core status
	input wire logic hv_supplied_in,
	input wire logic cap_charged_in,
	input wire logic fault_in,
	input wire logic lamp_flash_in,
	input wire logic energy_eval_in,
	input wire logic energy_in_range_in,
	input wire logic lamp_power_over_in,
	// Decoded controls to the welder core
	output logic beam_unit3_ready_out,
	output logic beam_unit4_ready_out,
	output logic [4:0] schedule_number_out,
	output logic hv_enable_out,
	// Relay status outputs, one means contact closed
	output logic ready_out,
	output logic hv_on_out,
	output logic trouble_ok_out,
	output logic end_out,
	output logic monitor_normal_out,
	output logic monitor_trouble_out,
	output logic ext_receivable_out,
	output logic lamp_power_ok_out
);
	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	logic [wxio_pkg::WXIO_IN_W-1:0] raw;
	logic [wxio_pkg::WXIO_IN_W-1:0] s;
	assign raw = {lamp_power_over_in, energy_in_range_in, energy_eval_in, lamp_flash_in,
		fault_in, cap_charged_in, hv_supplied_in, trouble_reset_in, hv_on_request_in,
		schedule_in, beam_select4_in, beam_select3_in, external_control_enable_in};

	wxio_sync u_sync
	(
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.async_in(raw),
		.sync_out(s)
	);

	function automatic logic [4:0] sched_sum(input logic [4:0] c);
		// Binary weights 1,2,4,8,16; 31 is not a stored schedule, hold at 30
		logic [4:0] v;
		v = c;
		if (v > wxio_pkg::WXIO_SCHED_MAX)
		begin
			v = wxio_pkg::WXIO_SCHED_MAX;
		end
		return v;
	endfunction

	// ----------------------------------------------------------------
	// External control decode and fault latch
	// ----------------------------------------------------------------
	logic ext_en;
	logic fault_latched;
	logic next_fault_latched;
	logic next_b3;
	logic next_b4;
	logic [4:0] next_sched;
	logic next_hv_en;
	logic flash_d;
	logic eval_d;
	logic flash_rise;
	logic eval_rise;

	always_comb
	begin
		ext_en = s[wxio_pkg::WXIO_IN_CHG];
		next_b3 = ext_en & s[wxio_pkg::WXIO_IN_BSEL3];
		next_b4 = ext_en & s[wxio_pkg::WXIO_IN_BSEL4];
		next_hv_en = ext_en & s[wxio_pkg::WXIO_IN_HVREQ];
		if (ext_en)
		begin
			next_sched = sched_sum(s[wxio_pkg::WXIO_IN_SCHED +: 5]);
		end
		else
		begin
			next_sched = schedule_number_out;
		end
		// Fault set wins over a reset arriving in the same cycle
		if (s[wxio_pkg::WXIO_IN_FAULT])
		begin
			next_fault_latched = 1'b1;
		end
		else if (ext_en && s[wxio_pkg::WXIO_IN_TRST])
		begin
			next_fault_latched = 1'b0;
		end
		else
		begin
			next_fault_latched = fault_latched;
		end
		flash_rise = s[wxio_pkg::WXIO_IN_FLASH] & ~flash_d;
		eval_rise = s[wxio_pkg::WXIO_IN_EVAL] & ~eval_d;
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			fault_latched <= 1'b0;
			beam_unit3_ready_out <= 1'b0;
			beam_unit4_ready_out <= 1'b0;
			schedule_number_out <= wxio_pkg::WXIO_SCHED_RESET;
			hv_enable_out <= 1'b0;
			flash_d <= 1'b0;
			eval_d <= 1'b0;
		end
		else
		begin
			fault_latched <= next_fault_latched;
			beam_unit3_ready_out <= next_b3;
			beam_unit4_ready_out <= next_b4;
			schedule_number_out <= next_sched;
			hv_enable_out <= next_hv_en;
			flash_d <= s[wxio_pkg::WXIO_IN_FLASH];
			eval_d <= s[wxio_pkg::WXIO_IN_EVAL];
		end
	end

	// Decode and fault latch checks
	a_unit3_sel: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		ext_en && s[wxio_pkg::WXIO_IN_BSEL3] |=> beam_unit3_ready_out)
		else $error("unit 3 not selected");
	a_unit4_sel: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		ext_en && s[wxio_pkg::WXIO_IN_BSEL4] |=> beam_unit4_ready_out)
		else $error("unit 4 not selected");
	a_hv_request: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		ext_en && s[wxio_pkg::WXIO_IN_HVREQ] |=> hv_enable_out)
		else $error("hv request not passed on");
	a_ignore_ext: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		!ext_en |=> !beam_unit3_ready_out && !beam_unit4_ready_out && !hv_enable_out
			&& $stable(schedule_number_out))
		else $error("external input used while disabled");
	a_sched_sum: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		ext_en && s[wxio_pkg::WXIO_IN_SCHED +: 5] != 5'h1f
			|=> schedule_number_out == $past(s[wxio_pkg::WXIO_IN_SCHED +: 5]))
		else $error("schedule number is not the weight sum");
	a_sched_clamp: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		ext_en && s[wxio_pkg::WXIO_IN_SCHED +: 5] == 5'h1f
			|=> schedule_number_out == wxio_pkg::WXIO_SCHED_MAX)
		else $error("schedule code above 30 not held at 30");
	a_fault_opens: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		s[wxio_pkg::WXIO_IN_FAULT] |=> !trouble_ok_out)
		else $error("fault did not open trouble");
	a_trouble_hold: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		!trouble_ok_out && !(ext_en && s[wxio_pkg::WXIO_IN_TRST]) |=> !trouble_ok_out)
		else $error("trouble cleared without reset");
	a_trouble_clr: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		!s[wxio_pkg::WXIO_IN_FAULT] && ext_en && s[wxio_pkg::WXIO_IN_TRST] |=> trouble_ok_out)
		else $error("trouble reset did not clear the alarm");

	// ----------------------------------------------------------------
	// Status relays
	// ----------------------------------------------------------------
	logic next_ready;
	logic next_hv_on;
	logic next_trouble_ok;
	logic next_recv;
	logic next_lamp_ok;
	logic trig_norm;
	logic trig_bad;

	always_comb
	begin
		next_ready = s[wxio_pkg::WXIO_IN_HVON] & s[wxio_pkg::WXIO_IN_CHARGED];
		next_hv_on = s[wxio_pkg::WXIO_IN_HVON];
		next_trouble_ok = ~next_fault_latched;
		next_recv = s[wxio_pkg::WXIO_IN_CHG];
		next_lamp_ok = ~s[wxio_pkg::WXIO_IN_LAMPOVER];
		trig_norm = eval_rise & s[wxio_pkg::WXIO_IN_INRANGE];
		trig_bad = eval_rise & ~s[wxio_pkg::WXIO_IN_INRANGE];
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ready_out <= 1'b0;
			hv_on_out <= 1'b0;
			trouble_ok_out <= 1'b1;
			ext_receivable_out <= 1'b0;
			lamp_power_ok_out <= 1'b1;
		end
		else
		begin
			ready_out <= next_ready;
			hv_on_out <= next_hv_on;
			trouble_ok_out <= next_trouble_ok;
			ext_receivable_out <= next_recv;
			lamp_power_ok_out <= next_lamp_ok;
		end
	end

	// Status relay checks
	a_ready_cause: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		ready_out |-> $past(s[wxio_pkg::WXIO_IN_HVON]) && $past(s[wxio_pkg::WXIO_IN_CHARGED]))
		else $error("ready without high voltage and charge");
	a_ready_set: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		s[wxio_pkg::WXIO_IN_HVON] && s[wxio_pkg::WXIO_IN_CHARGED] |=> ready_out)
		else $error("ready missing with high voltage and charge");
	a_hv_follow: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		##1 hv_on_out == $past(s[wxio_pkg::WXIO_IN_HVON]))
		else $error("hv status does not follow supply");
	a_recv_follow: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		##1 ext_receivable_out == $past(ext_en))
		else $error("receivable does not follow changeover");
	a_lamp_limit: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		s[wxio_pkg::WXIO_IN_LAMPOVER] |=> !lamp_power_ok_out)
		else $error("lamp limit not opened");
	a_lamp_normal: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		!s[wxio_pkg::WXIO_IN_LAMPOVER] |=> lamp_power_ok_out)
		else $error("lamp limit open without excess power");

	// ----------------------------------------------------------------
	// 40 ms pulse outputs
	// ----------------------------------------------------------------
	wxio_pulse u_end
	(
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.trig_in(flash_rise),
		.stop_in(1'b0),
		.pulse_out(end_out)
	);

	// A new verdict ends the opposite pulse so only one shows
	wxio_pulse u_mon_norm
	(
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.trig_in(trig_norm),
		.stop_in(trig_bad),
		.pulse_out(monitor_normal_out)
	);

	wxio_pulse u_mon_bad
	(
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.trig_in(trig_bad),
		.stop_in(trig_norm),
		.pulse_out(monitor_trouble_out)
	);

	// Pulse output checks
	a_end_pulse: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		flash_rise |=> end_out [*8])
		else $error("end pulse too short");
	a_end_start: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		$rose(end_out) |-> $past(flash_rise))
		else $error("end pulse without a flash");
	a_mon_excl: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		!(monitor_normal_out && monitor_trouble_out))
		else $error("both monitor outputs closed");
	a_mon_norm: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		trig_norm |=> monitor_normal_out ##1 monitor_normal_out)
		else $error("monitor normal missing");
	a_norm_start: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		$rose(monitor_normal_out) |-> $past(trig_norm))
		else $error("monitor normal without an in-range verdict");
	a_mon_bad: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		trig_bad |=> monitor_trouble_out ##1 monitor_trouble_out)
		else $error("monitor trouble missing");
	a_bad_start: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		$rose(monitor_trouble_out) |-> $past(trig_bad))
		else $error("monitor trouble without an out-of-range verdict");
endmodule
`default_nettype wire

// ==== dv/wxio_ctrl_model.sv ====
// Behavioural machine controller that drives the contact inputs of the welder.
// Assumes the bench asks for contact levels; the contacts move on the next clock edge.
`timescale 1ns/1ps
`default_nettype none
module wxio_ctrl_model
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	// Requested levels: chg, unit3, unit4, schedule[4:0], hv request, trouble reset
	input wire logic [9:0] cmd_in,
	// Contact lines, one means closed
	output logic changeover_out,
	output logic beam3_out,
	output logic beam4_out,
	output logic [4:0] schedule_out,
	output logic hv_request_out,
	output logic trouble_reset_out
);
	// ----------------------------------------------------------------
	// Contact state
	// ----------------------------------------------------------------
	logic [9:0] contact;
	logic [9:0] next_contact;
	always_comb
	begin
		next_contact = cmd_in;
	end
	// All contacts open while reset is held
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			contact <= 10'h000;
		else
			contact <= next_contact;
	end
	assign changeover_out = contact[0];
	assign beam3_out = contact[1];
	assign beam4_out = contact[2];
	assign schedule_out = contact[7:3];
	assign hv_request_out = contact[8];
	assign trouble_reset_out = contact[9];
endmodule
`default_nettype wire

// ==== dv/wxio_top_bench.sv ====
// Self-checking bench for the welder external discrete control block.
// Assumes the controller model owns the contact lines; core status is driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) \
		begin \
			err_count++; \
			$display("wrong value %s expected %h seen %h", nm, exp, got); \
		end \
	end
module wxio_top_bench;
	logic clk_sys_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [9:0] cmd = 10'h000;
	// Core: hv, charged, fault, flash, eval, in range, lamp over
	logic [6:0] core = 7'h00;
	logic chg, b3, b4, hvr, trs;
	logic [4:0] sch;
	logic u3, u4, hve, rdy, hvo, tok, endp, mn, mt, rcv, lok;
	logic [4:0] snum;
	logic [4:0] es;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #10 clk_sys_in = ~clk_sys_in;
	wxio_ctrl_model wxio_ctrl_model_i (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.cmd_in(cmd), .changeover_out(chg), .beam3_out(b3), .beam4_out(b4),
		.schedule_out(sch), .hv_request_out(hvr), .trouble_reset_out(trs));
	wxio_top wxio_top_i (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.external_control_enable_in(chg), .beam_select3_in(b3), .beam_select4_in(b4),
		.schedule_in(sch), .hv_on_request_in(hvr), .trouble_reset_in(trs),
		.hv_supplied_in(core[0]), .cap_charged_in(core[1]), .fault_in(core[2]),
		.lamp_flash_in(core[3]), .energy_eval_in(core[4]), .energy_in_range_in(core[5]),
		.lamp_power_over_in(core[6]), .beam_unit3_ready_out(u3), .beam_unit4_ready_out(u4),
		.schedule_number_out(snum), .hv_enable_out(hve), .ready_out(rdy), .hv_on_out(hvo),
		.trouble_ok_out(tok), .end_out(endp), .monitor_normal_out(mn),
		.monitor_trouble_out(mt), .ext_receivable_out(rcv), .lamp_power_ok_out(lok));
	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic give_verdict;
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic setc(input logic [9:0] v);
		@(posedge clk_sys_in);
		cmd <= v;
		tick(6);
	endtask
	task automatic setk(input logic [6:0] v);
		@(posedge clk_sys_in);
		core <= v;
		tick(5);
	endtask
	// Cuts a hang short
	always @(posedge clk_sys_in)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			give_verdict();
		end
	end
	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		tick(1);
		`CHK("trouble_ok", 1'b1, tok)
		`CHK("lamp_ok", 1'b1, lok)
		`CHK("schedule", 5'h00, snum)
		`CHK("end", 1'b0, endp)
		setc(10'h001);
		`CHK("receivable", 1'b1, rcv)
		setc(10'h003);
		`CHK("unit3", 1'b1, u3)
		`CHK("unit4", 1'b0, u4)
		setc(10'h005);
		`CHK("unit4", 1'b1, u4)
		`CHK("unit3", 1'b0, u3)
		setc(10'h101);
		`CHK("hv_enable", 1'b1, hve)
		for (int i = 0; i < 32; i++)
		begin
			es = (i == 31) ? 5'h1e : 5'(i);
			setc({2'b00, 5'(i), 3'b001});
			`CHK("schedule", es, snum)
		end
		// Changeover open: unit selects, hv request and schedule code 0b closed but ignored
		setc({2'b01, 5'h0b, 3'b110});
		`CHK("receivable", 1'b0, rcv)
		`CHK("unit3", 1'b0, u3)
		`CHK("unit4", 1'b0, u4)
		`CHK("hv_enable", 1'b0, hve)
		`CHK("schedule", 5'h1e, snum)
		for (int j = 0; j < 4; j++)
		begin
			setk({5'h00, 2'(j)});
			`CHK("ready", (j == 3), rdy)
			`CHK("hv_on", 1'(j), hvo)
		end
		setk(7'h40);
		`CHK("lamp_ok", 1'b0, lok)
		setk(7'h00);
		`CHK("lamp_ok", 1'b1, lok)
		setk(7'h04);
		`CHK("trouble_ok", 1'b0, tok)
		setk(7'h00);
		`CHK("trouble_ok", 1'b0, tok)
		setc(10'h200);
		`CHK("trouble_ok", 1'b0, tok)
		setc(10'h201);
		`CHK("trouble_ok", 1'b1, tok)
		setc(10'h001);
		// Flash: pulse shows three edges after the core raises it
		@(posedge clk_sys_in);
		core <= 7'h08;
		tick(2);
		`CHK("end", 1'b0, endp)
		tick(1);
		`CHK("end", 1'b1, endp)
		@(posedge clk_sys_in);
		core <= 7'h00;
		tick(1000);
		`CHK("end", 1'b1, endp)
		setk(7'h30);
		setk(7'h20);
		`CHK("mon_normal", 1'b1, mn)
		`CHK("mon_trouble", 1'b0, mt)
		setk(7'h10);
		`CHK("mon_trouble", 1'b1, mt)
		`CHK("mon_normal", 1'b0, mn)
		setk(7'h00);
		setk(7'h04);
		setk(7'h00);
		`CHK("trouble_ok", 1'b0, tok)
		// Mid-run reset clears the latched fault and cuts both running pulses
		@(posedge clk_sys_in);
		arst_n_in <= 1'b0;
		tick(2);
		`CHK("end", 1'b0, endp)
		`CHK("mon_trouble", 1'b0, mt)
		`CHK("trouble_ok", 1'b1, tok)
		@(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		tick(1);
		`CHK("receivable", 1'b0, rcv)
		setc(10'h001);
		`CHK("receivable", 1'b1, rcv)
		`CHK("trouble_ok", 1'b1, tok)
		give_verdict();
	end
endmodule
`default_nettype wire
